// File: sim/buck_mode_and_boost_pwm_ctrl_tb.sv
// Self-checking bench for the power control core
`timescale 1ns/1ps
`default_nettype none
module buck_mode_and_boost_pwm_ctrl_tb;
  import pwm_ctrl_pkg::*;
  // Short main period keeps mode runs brief
  localparam int DIV = 12;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_w = 32'h0;
  logic [31:0] dat_r;
  logic ack;
  logic glob = 1'b0;
  logic en5 = 1'b0;
  logic en3 = 1'b0;
  logic [1:0] phase = 2'h0;
  logic [1:0] pend = 2'h0;
  logic [1:0] hlow = 2'h0;
  logic [1:0] hhigh = 2'h0;
  logic [1:0] drop = 2'h0;
  logic [1:0] hs_low;
  logic [1:0] ls_low;
  logic sense = 1'b0;
  logic ramp = 1'b0;
  logic slow = 1'b0;
  logic aon, m5, m3, bgate, bclk;
  logic [1:0] hs, ls;
  logic [1:0] hs_prev = 2'h0;
  logic [1:0] ls_prev = 2'h0;
  logic [31:0] rd;
  int n_errors = 0;
  int checks = 0;
  int seed = 32'h0410;

  initial
  begin
    forever #2.5 CLK = ~CLK;
  end

  pwr_ctrl_top #(.MAIN_DIV_P(DIV)) dut_u
  (
    .CLK(CLK), .RST(RST), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
    .GLOBAL_OUTPUT_ENABLE(glob), .MAIN5_CHANNEL_ENABLE(en5), .MAIN3_CHANNEL_ENABLE(en3),
    .PHASE_CMP(phase), .PWM_END(pend), .HYST_LOW(hlow), .HYST_HIGH(hhigh),
    .OUT_DROP(drop), .HS_GATE_LOW(hs_low), .LS_GATE_LOW(ls_low),
    .BOOST_FEEDBACK_SENSE(sense), .RAMP_ABOVE_ERROR(ramp), .ALWAYS_ON_EN(aon),
    .MAIN5_EN(m5), .MAIN3_EN(m3), .HS_GATE(hs), .LS_GATE(ls), .BOOST_GATE(bgate),
    .BOOST_RAMP_CLK(bclk)
  );

  gate_vgs_model model_u
  (
    .clk(CLK), .hs_gate(hs), .ls_gate(ls), .slow(slow), .hs_low(hs_low), .ls_low(ls_low)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  task automatic give_up(input logic hit);
    if (hit)
    begin
      n_errors++;
      print_verdict();
    end
  endtask : give_up

  function automatic logic [2:0] en_exp(input logic [2:0] v);
    return {v[2] & v[0], v[2] & v[1], v[2]};
  endfunction : en_exp

  function automatic logic pick(input int w);
    return w == 0 ? bclk : hs[0];
  endfunction : pick

  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    int k;
    @(posedge CLK);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat_w <= d;
    k = 0;
    do
    begin
      @(posedge CLK);
      k++;
    end
    while (ack !== 1'b1 && k < 50);
    give_up(k >= 50);
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic wait_sig(input int w, input logic v);
    int k;
    k = 0;
    while (pick(w) !== v && k < 200)
    begin
      @(posedge CLK);
      k++;
    end
    give_up(k >= 200);
    check(32'(pick(w)), 32'(v));
  endtask : wait_sig

  task automatic stat(input logic [1:0] e);
    wb(1'b0, ADDR_STATUS, 4'hF, 32'h0);
    check(32'(rd[1:0]), 32'(e));
  endtask : stat

  task automatic quiet(input int w);
    logic acc;
    acc = 1'b0;
    repeat (5) @(posedge CLK);
    repeat (3 * DIV)
    begin
      @(posedge CLK);
      acc = acc | pick(w) | (w == 0 && bgate);
    end
    check(32'(acc), 32'h0);
  endtask : quiet

  // Random on-time ends, and dead-time watch on every gate turn-on
  always @(posedge CLK)
  begin
    pend <= 2'($random(seed));
    for (int i = 0; i < 2; i++)
    begin
      if (hs[i] === 1'b1 && hs_prev[i] !== 1'b1)
        check(32'(ls_low[i]), 32'h1);
      if (ls[i] === 1'b1 && ls_prev[i] !== 1'b1)
        check(32'(hs_low[i]), 32'h1);
    end
    hs_prev <= hs;
    ls_prev <= ls;
  end

  initial
  begin
    logic [31:0] d;
    int n;
    repeat (3) @(posedge CLK);
    RST <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      {glob, en5, en3} <= 3'(i);
      repeat (5) @(posedge CLK);
      check(32'({m3, m5, aon}), 32'(en_exp(3'(i))));
    end
    wb(1'b0, ADDR_STATUS, 4'hF, 32'h0);
    check(32'(rd[8:6]), 32'h7);
    // Write with no byte lane enabled must leave the register alone
    d = $random(seed);
    wb(1'b1, ADDR_CTRL, 4'hF, d);
    wb(1'b1, ADDR_CTRL, 4'h0, ~d);
    wb(1'b0, ADDR_CTRL, 4'hF, 32'h0);
    check(rd, d & 32'h3);
    wb(1'b0, 8'h80, 4'hF, 32'h0);
    check(rd, 32'h0);
    wb(1'b1, ADDR_CTRL, 4'hF, 32'h0);
    // Broken run of positive samples, then an unbroken one
    slow <= 1'b1;
    phase <= 2'h3;
    repeat (6 * DIV) @(posedge CLK);
    phase <= 2'h0;
    repeat (2 * DIV) @(posedge CLK);
    phase <= 2'h3;
    repeat (6 * DIV) @(posedge CLK);
    stat(2'h0);
    repeat (4 * DIV) @(posedge CLK);
    stat(2'h3);
    check(32'({hs, ls}), 32'h0);
    slow <= 1'b0;
    hlow <= 2'h1;
    wait_sig(1, 1'b1);
    hlow <= 2'h0;
    hhigh <= 2'h1;
    wait_sig(1, 1'b0);
    hhigh <= 2'h0;
    quiet(1);
    drop <= 2'h1;
    repeat (2 * DIV) @(posedge CLK);
    drop <= 2'h0;
    stat(2'h2);
    phase <= 2'h0;
    repeat (10 * DIV) @(posedge CLK);
    stat(2'h0);
    // Force bit holds one channel in PWM and pulls the other back
    wb(1'b1, ADDR_CTRL, 4'h1, 32'h1);
    phase <= 2'h3;
    repeat (10 * DIV) @(posedge CLK);
    stat(2'h2);
    wb(1'b1, ADDR_CTRL, 4'h1, 32'h2);
    repeat (2 * DIV) @(posedge CLK);
    stat(2'h0);
    repeat (8 * DIV) @(posedge CLK);
    stat(2'h1);
    wb(1'b1, ADDR_CTRL, 4'h1, 32'h0);
    phase <= 2'h0;
    ramp <= 1'b1;
    wait_sig(0, 1'b0);
    wait_sig(0, 1'b1);
    repeat (DIV - 1) @(posedge CLK);
    check(32'({bclk, bgate}), 32'h3);
    @(posedge CLK);
    check(32'({bclk, bgate}), 32'h0);
    @(posedge CLK);
    check(32'(bgate), 32'h0);
    n = DIV + 1;
    while (bclk !== 1'b1 && n < 200)
    begin
      @(posedge CLK);
      n++;
    end
    check(32'(n), 32'(3 * DIV));
    sense <= 1'b1;
    quiet(0);
    wb(1'b0, ADDR_STATUS, 4'hF, 32'h0);
    check(32'(rd[10:9]), 32'h2);
    sense <= 1'b0;
    en5 <= 1'b0;
    quiet(0);
    glob <= 1'b0;
    repeat (5) @(posedge CLK);
    check(32'({aon, m5, m3, hs, ls}), 32'h0);
    print_verdict();
  end
endmodule : buck_mode_and_boost_pwm_ctrl_tb
`default_nettype wire

// File: sim/gate_vgs_model.sv
// Gate driver model: Vgs comparators that report off some cycles after turn-off
`timescale 1ns/1ps
`default_nettype none
module gate_vgs_model
(
  // Clock
  input wire logic clk,
  // Gate drives and speed select
  input wire logic [1:0] hs_gate,
  input wire logic [1:0] ls_gate,
  input wire logic slow,
  // Vgs below threshold, high means off
  output logic [1:0] hs_low,
  output logic [1:0] ls_low
);
  // Saturating turn-off age; slow gates stretch the dead time
  logic [2:0] age [4] = '{3'h7, 3'h7, 3'h7, 3'h7};
  logic [3:0] drv;
  logic [3:0] low;
  assign drv = {ls_gate, hs_gate};
  always @(posedge clk)
  begin
    for (int i = 0; i < 4; i++)
      age[i] <= drv[i] ? 3'h0 : age[i] + 3'(age[i] != 3'h7);
  end
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      low[i] = !drv[i] && age[i] >= (slow ? 3'h4 : 3'h1);
  end
  assign hs_low = low[1:0];
  assign ls_low = low[3:2];
endmodule : gate_vgs_model
`default_nettype wire

// File: verilog/buck_chan.sv
// One buck channel: mode control, hysteretic pulses and gate interlock
`timescale 1ns/1ps
`default_nettype none
module buck_chan
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Channel signals
  chan_if.chan c
);
  import pwm_ctrl_pkg::*;

  chan_st_t q;
  chan_st_t n;
  logic active;
  logic sample_match;

  always_comb
  begin
    n = q;
    active = 1'b0;
    sample_match = 1'b0;
    if (!c.enable)
    begin
      n = CHAN_RESET;
    end
    else
    begin
      if (c.pre_tick)
      begin
        // Match means a sample pointing away from the present mode
        sample_match = (c.phase_s == (q.mode == MODE_PWM));
        n.run = sample_match ? q.run + 4'h1 : 4'h0;
        if (sample_match && (q.run + 4'h1 == RUN_LEN))
        begin
          n.run = 4'h0;
          if (q.mode == MODE_PWM && !c.force_pwm)
          begin
            n.mode = MODE_HYST;
            n.pulse = 1'b0;
            n.pulse_pend = 1'b0;
            n.hi_phase = 1'b0;
          end
          else if (q.mode == MODE_HYST)
          begin
            n.mode = MODE_PWM;
          end
        end
      end
      if (q.mode == MODE_HYST)
      begin
        if (c.out_drop)
        begin
          n.drop_pend = 1'b1;
        end
        if (c.main_tick && (q.drop_pend || c.force_pwm))
        begin
          n.mode = MODE_PWM;
          n.drop_pend = 1'b0;
        end
        if (c.hyst_low)
        begin
          n.pulse_pend = 1'b1;
        end
        // Pulse begins only on a main tick so channel phasing holds
        if (c.main_tick && q.pulse_pend)
        begin
          n.pulse = 1'b1;
          n.pulse_pend = 1'b0;
        end
        if (c.hyst_high)
        begin
          n.pulse = 1'b0;
          n.pulse_pend = 1'b0;
        end
      end
      else
      begin
        n.drop_pend = 1'b0;
        n.pulse = 1'b0;
        n.pulse_pend = 1'b0;
      end
      active = (n.mode == MODE_PWM) || n.pulse;
      if (!active)
      begin
        n.hi_phase = 1'b0;
      end
      else if (c.main_tick)
      begin
        n.hi_phase = 1'b1;
      end
      else if (c.pwm_end)
      begin
        n.hi_phase = 1'b0;
      end
    end
    n.hs = active && n.hi_phase && c.ls_low && !q.ls;
    n.ls = active && !n.hi_phase && c.hs_low && !q.hs;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q <= CHAN_RESET;
    end
    else
    begin
      q <= n;
    end
  end

  assign c.hs_gate = q.hs;
  assign c.ls_gate = q.ls;
  assign c.hyst_mode = (q.mode == MODE_HYST);

  a_hyst_entry: assert property (@(posedge clk) disable iff (rst)
    (c.enable && q.mode == MODE_PWM && n.mode == MODE_HYST)
      |-> (q.run == 4'h7 && c.pre_tick && c.phase_s))
    else $error("hysteretic entry without eight high samples");
  a_entry_off: assert property (@(posedge clk) disable iff (rst)
    (c.enable && q.mode == MODE_PWM && n.mode == MODE_HYST) |=> (!q.hs && !q.ls))
    else $error("gates not off at hysteretic entry");
  a_pwm_return: assert property (@(posedge clk) disable iff (rst)
    (c.enable && q.mode == MODE_HYST && n.mode == MODE_PWM)
      |-> ((q.run == 4'h7 && c.pre_tick && !c.phase_s) || (c.main_tick
      && (q.drop_pend || c.force_pwm))))
    else $error("PWM return without cause");
  a_drop_exit: assert property (@(posedge clk) disable iff (rst)
    (c.enable ##0 q.mode == MODE_HYST && q.drop_pend && c.main_tick ##1 c.enable)
      |-> q.mode == MODE_PWM)
    else $error("output drop did not force PWM");
  a_run_clear: assert property (@(posedge clk) disable iff (rst)
    (c.enable && c.pre_tick && (c.phase_s != (q.mode == MODE_PWM))) |=> q.run == 4'h0)
    else $error("opposite sample kept the run");
  a_hs_dead: assert property (@(posedge clk) disable iff (rst)
    $rose(q.hs) |-> ($past(c.ls_low) && !$past(q.ls)))
    else $error("high side on before low side off");
  a_ls_dead: assert property (@(posedge clk) disable iff (rst)
    $rose(q.ls) |-> ($past(c.hs_low) && !$past(q.hs)))
    else $error("low side on before high side off");
  a_tick_align: assert property (@(posedge clk) disable iff (rst)
    $rose(q.hi_phase) |-> $past(c.main_tick))
    else $error("on-time not aligned to main clock");

endmodule : buck_chan
`default_nettype wire

// File: verilog/chan_if.sv
// Interface between the top and one buck channel controller
`timescale 1ns/1ps
`default_nettype none
interface chan_if;
  logic main_tick;
  logic pre_tick;
  logic enable;
  logic force_pwm;
  logic phase_s;
  logic pwm_end;
  logic hyst_low;
  logic hyst_high;
  logic out_drop;
  logic hs_low;
  logic ls_low;
  logic hs_gate;
  logic ls_gate;
  logic hyst_mode;
  modport ctl (output main_tick, pre_tick, enable, force_pwm, phase_s, pwm_end, hyst_low,
    hyst_high, out_drop, hs_low, ls_low, input hs_gate, ls_gate, hyst_mode);
  modport chan (input main_tick, pre_tick, enable, force_pwm, phase_s, pwm_end, hyst_low,
    hyst_high, out_drop, hs_low, ls_low, output hs_gate, ls_gate, hyst_mode);
endinterface : chan_if
`default_nettype wire

// File: verilog/pwm_ctrl_pkg.sv
// Package of constants and types for the buck mode and boost PWM control core
// Behaviour
// - Sample phase comparator just before high-side turn-on.
// - Low sample means forward current, high means reverse.
// - Eight consecutive high samples move PWM to hysteretic.
// - Entering hysteretic mode turns both gates off.
// - Eight consecutive low samples return to PWM.
// - Output drop forces PWM at next main clock.
// - Hysteretic pulse starts at lower, ends at upper limit.
// - Hysteretic gate pulses stay aligned to main clock.
// - Low-side waits until high-side gate is low.
// - High-side waits until low-side gate is low.
// - Global enable low keeps every output off.
// - Each buck needs its channel and global enable.
// - Global high, channels low gives stand-by.
// - Boost clock is main clock divided by three.
// - Divided boost pulse lasts one main period.
// - Ramp above error sets the boost latch.
// - Falling edge of divided pulse resets latch.
// - Disable-detect input turns the boost controller off.
// - Boost runs whenever the 5V buck is enabled and the disable-detect input is low.
package pwm_ctrl_pkg;

  localparam int unsigned CLK_KHZ = 200000;
  localparam int unsigned MAIN_KHZ = 300;
  localparam int unsigned MAIN_DIV = CLK_KHZ / MAIN_KHZ;
  localparam int unsigned CNT_W = 10;
  localparam logic [1:0] BOOST_LAST = 2'h2;
  localparam logic [3:0] RUN_LEN = 4'h8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;

  typedef enum logic {MODE_PWM, MODE_HYST} mode_t;

  typedef struct packed {
    mode_t mode;
    logic [3:0] run;
    logic drop_pend;
    logic pulse_pend;
    logic pulse;
    logic hi_phase;
    logic hs;
    logic ls;
  } chan_st_t;

  localparam chan_st_t CHAN_RESET = '{MODE_PWM, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

  typedef struct packed {
    logic glob;
    logic en5;
    logic en3;
    logic boost_dis;
    logic ramp_above;
    logic [1:0] phase;
    logic [1:0] pwm_end;
    logic [1:0] hyst_low;
    logic [1:0] hyst_high;
    logic [1:0] out_drop;
    logic [1:0] hs_low;
    logic [1:0] ls_low;
  } pins_t;

  typedef struct packed {
    logic [20:0] rsv;
    logic boost_dis;
    logic boost_gate;
    logic [2:0] en;
    logic [1:0] ls;
    logic [1:0] hs;
    logic [1:0] hyst;
  } status_t;

endpackage : pwm_ctrl_pkg

// File: verilog/pwr_ctrl_top.sv
// Top of the power control core: pins, enables, boost PWM and Wishbone registers
//
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pwr_ctrl_top
#(
  parameter int unsigned MAIN_DIV_P = pwm_ctrl_pkg::MAIN_DIV
)
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // System enables
  input wire logic GLOBAL_OUTPUT_ENABLE,
  input wire logic MAIN5_CHANNEL_ENABLE,
  input wire logic MAIN3_CHANNEL_ENABLE,
  // Buck comparators, index 0 is 5V, index 1 is 3.3V
  input wire logic [1:0] PHASE_CMP,
  input wire logic [1:0] PWM_END,
  input wire logic [1:0] HYST_LOW,
  input wire logic [1:0] HYST_HIGH,
  input wire logic [1:0] OUT_DROP,
  input wire logic [1:0] HS_GATE_LOW,
  input wire logic [1:0] LS_GATE_LOW,
  // Boost comparators
  input wire logic BOOST_FEEDBACK_SENSE,
  input wire logic RAMP_ABOVE_ERROR,
  // Rail enables
  output logic ALWAYS_ON_EN,
  output logic MAIN5_EN,
  output logic MAIN3_EN,
  // Gate drives
  output logic [1:0] HS_GATE,
  output logic [1:0] LS_GATE,
  output logic BOOST_GATE,
  output logic BOOST_RAMP_CLK
);
  import pwm_ctrl_pkg::*;

  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(MAIN_DIV_P - 1);
  localparam logic [CNT_W-1:0] CNT_HALF = CNT_W'(MAIN_DIV_P / 2);

  typedef struct packed {
    pins_t s1;
    pins_t s2;
    logic [CNT_W-1:0] cnt;
    logic [1:0] boost_div;
    logic boost_clk3;
    logic boost_latch;
    logic [1:0] force_pwm;
    logic ack;
    logic [31:0] dat;
  } top_st_t;

  top_st_t q;
  top_st_t n;
  pins_t pins;
  status_t stat;
  logic main_tick;
  logic boost_en;
  logic boost_fall;
  logic [1:0] hyst_mode;
  logic [1:0] chan_en;
  logic [1:0] hs_g;
  logic [1:0] ls_g;

  // Counter value that fires a tick for a channel with the given offset
  function automatic logic at_offset(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] ofs,
    input logic early);
    logic [CNT_W-1:0] target;
    target = ofs;
    if (early)
    begin
      target = (ofs == '0) ? CNT_LAST : ofs - CNT_W'(1);
    end
    return cnt == target;
  endfunction : at_offset

  assign pins = '{GLOBAL_OUTPUT_ENABLE, MAIN5_CHANNEL_ENABLE, MAIN3_CHANNEL_ENABLE,
    BOOST_FEEDBACK_SENSE, RAMP_ABOVE_ERROR, PHASE_CMP, PWM_END, HYST_LOW, HYST_HIGH,
    OUT_DROP, HS_GATE_LOW, LS_GATE_LOW};

  assign ALWAYS_ON_EN = q.s2.glob;
  assign MAIN5_EN = q.s2.glob && q.s2.en5;
  assign MAIN3_EN = q.s2.glob && q.s2.en3;
  assign chan_en = {MAIN3_EN, MAIN5_EN};
  // Boost follows the 5V buck unless its feedback is strapped high
  assign boost_en = MAIN5_EN && !q.s2.boost_dis;
  assign main_tick = (q.cnt == '0);

  // Two buck channels run half a main period apart
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_chan
      chan_if cif ();
      localparam logic [CNT_W-1:0] OFS = (gi == 0) ? '0 : CNT_HALF;
      assign cif.main_tick = at_offset(q.cnt, OFS, 1'b0);
      assign cif.pre_tick = at_offset(q.cnt, OFS, 1'b1);
      assign cif.enable = chan_en[gi];
      assign cif.force_pwm = q.force_pwm[gi];
      assign cif.phase_s = q.s2.phase[gi];
      assign cif.pwm_end = q.s2.pwm_end[gi];
      assign cif.hyst_low = q.s2.hyst_low[gi];
      assign cif.hyst_high = q.s2.hyst_high[gi];
      assign cif.out_drop = q.s2.out_drop[gi];
      assign cif.hs_low = q.s2.hs_low[gi];
      assign cif.ls_low = q.s2.ls_low[gi];
      assign hs_g[gi] = cif.hs_gate;
      assign ls_g[gi] = cif.ls_gate;
      assign hyst_mode[gi] = cif.hyst_mode;
      buck_chan u_chan
      (
        .clk (CLK),
        .rst (RST),
        .c (cif.chan)
      );
    end
  endgenerate

  always_comb
  begin
    n = q;
    n.s1 = pins;
    n.s2 = q.s1;
    n.cnt = (q.cnt == CNT_LAST) ? '0 : q.cnt + CNT_W'(1);
    boost_fall = 1'b0;
    if (main_tick)
    begin
      n.boost_div = (q.boost_div == BOOST_LAST) ? 2'h0 : q.boost_div + 2'h1;
      n.boost_clk3 = (n.boost_div == 2'h0);
      boost_fall = q.boost_clk3;
    end
    if (!boost_en || boost_fall)
    begin
      n.boost_latch = 1'b0;
    end
    else if (q.boost_clk3 && q.s2.ramp_above)
    begin
      n.boost_latch = 1'b1;
    end
    stat = '0;
    stat.boost_dis = q.s2.boost_dis;
    stat.boost_gate = q.boost_latch;
    stat.en = {MAIN3_EN, MAIN5_EN, ALWAYS_ON_EN};
    stat.ls = ls_g;
    stat.hs = hs_g;
    stat.hyst = hyst_mode;
    n.ack = WB_CYC_I && WB_STB_I && !q.ack;
    if (n.ack)
    begin
      n.dat = '0;
      unique case (WB_ADR_I)
        ADDR_CTRL:
        begin
          n.dat = {30'h00000000, q.force_pwm};
          if (WB_WE_I && WB_SEL_I[0])
          begin
            n.force_pwm = WB_DAT_I[1:0];
          end
        end
        ADDR_STATUS:
        begin
          n.dat = stat;
        end
        default:
        begin
          n.dat = '0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      q <= '0;
    end
    else
    begin
      q <= n;
    end
  end

  // Gates are forced low outside the enables as a second line of defence
  assign HS_GATE = hs_g & chan_en;
  assign LS_GATE = ls_g & chan_en;
  assign BOOST_GATE = q.boost_latch && boost_en;
  assign BOOST_RAMP_CLK = q.boost_clk3 && boost_en;
  assign WB_DAT_O = q.dat;
  assign WB_ACK_O = q.ack;

  a_global_off: assert property (@(posedge CLK) disable iff (RST)
    !q.s2.glob |-> (!ALWAYS_ON_EN && !MAIN5_EN && !MAIN3_EN && HS_GATE == 2'h0
      && LS_GATE == 2'h0 && !BOOST_GATE))
    else $error("output active with global enable low");
  a_stand_by: assert property (@(posedge CLK) disable iff (RST)
    (q.s2.glob && !q.s2.en5 && !q.s2.en3) |-> (ALWAYS_ON_EN && !MAIN5_EN && !MAIN3_EN))
    else $error("stand-by pattern wrong");
  a_boost_fall: assert property (@(posedge CLK) disable iff (RST)
    $fell(q.boost_clk3) |-> !q.boost_latch)
    else $error("boost latch survived pulse end");
  a_boost_set: assert property (@(posedge CLK) disable iff (RST)
    (boost_en && q.boost_clk3 && q.s2.ramp_above && !boost_fall) |=> q.boost_latch)
    else $error("ramp above error did not set latch");
  // Both pulse edges follow a main tick, so the width is whole main periods
  a_boost_width: assert property (@(posedge CLK) disable iff (RST)
    $changed(q.boost_clk3) |-> ($past(q.cnt) == '0 && q.cnt == CNT_W'(1)))
    else $error("divided pulse not aligned to main period");
  a_boost_disable: assert property (@(posedge CLK) disable iff (RST)
    q.s2.boost_dis |-> (!BOOST_GATE && !BOOST_RAMP_CLK))
    else $error("boost active while disabled");

endmodule : pwr_ctrl_top
`default_nettype wire
